/* src/ppm_control_status.sv */
// Operation
// RULE1: 16-bit control/status register four bytes past capability base.
// RULE2: Wake event flag sets on every wake event, enable or not.
// RULE3: Writing one clears the wake flag and releases the wake pin.
// RULE4: Writing zero to the wake flag leaves it unchanged.
// RULE5: Wake flag zero after reset without cold wake, else sticky.
// RULE6: Wake enable gates the pin; zero without cold wake, else sticky.
// RULE7: Sticky bits start undefined with cold wake, else read zero.
// RULE8: Two-bit read-only data scale field, zero without data register.
// RULE9: Four-bit data select field, zero without data register.
// RULE10: Power state field reads current state; writes request new state.
// RULE11: Power state codes 00 D0, 01 D1, 10 D2, 11 D3hot.
// RULE12: Unsupported state writes complete but are discarded.
// RULE13: Host writes reserved bits 7 to 2 as zero.
// RULE14: Cold wake strap sampled at power-on; high means supported.
// RULE15: Sticky bits kept on auxiliary power-on reset, survive bus reset; this design clears them to zero on auxRst.
`timescale 1ns/1ps
`default_nettype none
module ppm_control_status
  import ppm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic auxRst,
  input wire logic coldWakeStrap,
  input wire logic wakeRequest,
  input wire logic [1:0] dataScaleIn,
  input wire ppm_cfg_req_t cfgReq,
  output ppm_cfg_rsp_t cfgRsp,
  output ppm_pstate_t powerStateField,
  output logic powerStateChanged,
  output logic [3:0] dataSelect,
  output logic wakeEventFlag,
  output logic wakeAssertEnable,
  output logic coldWakeSupported,
  output logic wakePinOut,
  output logic wakePinOe
);

  // ---------------------------------------------------------------
  // Local state
  // ---------------------------------------------------------------
  typedef struct packed {
    ppm_pstate_t pstate;
    logic changed;
    logic [3:0] select;
    logic [1:0] scale;
    ppm_cfg_rsp_t rsp;
  } ppm_ctl_state_t;

  ppm_ctl_state_t st;
  ppm_ctl_state_t next_st;

  logic hit;
  logic writeLow;
  logic writeHigh;
  logic flagClear;
  logic enableWrite;
  logic stateOk;
  ppm_pstate_t reqState;
  logic [15:0] readWord;

  // ---------------------------------------------------------------
  // Address decode and write strobes
  // ---------------------------------------------------------------
  assign hit = (cfgReq.addr == PMCS_ADDR); // see RULE1
  assign writeLow = cfgReq.write && hit && cfgReq.byteEn[0];
  assign writeHigh = cfgReq.write && hit && cfgReq.byteEn[1];

  // Only a one in the flag position clears it
  assign flagClear = writeHigh && cfgReq.data[WAKE_FLAG_BIT]; // see RULE4
  assign enableWrite = writeHigh;

  assign reqState = ppm_pstate_t'(cfgReq.data[STATE_MSB:STATE_LSB]);

  // ---------------------------------------------------------------
  // Supported state check
  // ---------------------------------------------------------------
  always_comb begin
    case (reqState)
      PPM_D0: stateOk = 1'b1; // see RULE11
      PPM_D1: stateOk = D1_SUPPORTED;
      PPM_D2: stateOk = D2_SUPPORTED;
      PPM_D3HOT: stateOk = 1'b1;
      default: stateOk = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Read word assembly
  // ---------------------------------------------------------------
  always_comb begin
    readWord = PMCS_RESET;
    readWord[WAKE_FLAG_BIT] = wakeEventFlag;
    readWord[SCALE_MSB:SCALE_LSB] = st.scale; // see RULE8
    readWord[SELECT_MSB:SELECT_LSB] = st.select; // see RULE9
    readWord[WAKE_EN_BIT] = wakeAssertEnable;
    // Reserved bits 7..2 always read zero, whatever the host wrote
    readWord[STATE_MSB:STATE_LSB] = st.pstate; // see RULE10
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.changed = 1'b0;
    next_st.rsp.valid = 1'b0;
    // Scale tracks the data logic; zero when no data register exists
    next_st.scale = HAS_DATA_REG ? dataScaleIn : SCALE_RESET; // see RULE8
    if (writeLow) begin
      // A refused state write still completes on the bus
      if (stateOk && (reqState != st.pstate)) begin
        next_st.pstate = reqState; // see RULE12
        next_st.changed = 1'b1;
      end
    end
    if (writeHigh && HAS_DATA_REG) begin
      next_st.select = cfgReq.data[SELECT_MSB:SELECT_LSB]; // see RULE9
    end
    if (cfgReq.read) begin
      next_st.rsp.valid = 1'b1;
      // Unmapped offsets answer with zero
      next_st.rsp.data = hit ? readWord : PMCS_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st.pstate <= PPM_D0;
      st.changed <= 1'b0;
      st.select <= SELECT_RESET;
      st.scale <= SCALE_RESET;
      st.rsp <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Wake event logic on the aux domain
  // ---------------------------------------------------------------
  ppm_wake_unit wake (
    .sysClk(sys_clk),
    .rst(rst),
    .auxRst(auxRst),
    .coldWakeStrap(coldWakeStrap),
    .wakeRequest(wakeRequest),
    .enableWrite(enableWrite),
    .enableValue(cfgReq.data[WAKE_EN_BIT]),
    .flagClear(flagClear),
    .wakeEventFlag(wakeEventFlag),
    .wakeAssertEnable(wakeAssertEnable),
    .coldWakeSupported(coldWakeSupported),
    .wakePinOut(wakePinOut),
    .wakePinOe(wakePinOe)
  );

  assign cfgRsp = st.rsp;
  assign powerStateField = st.pstate;
  assign powerStateChanged = st.changed;
  assign dataSelect = st.select;

endmodule
`default_nettype wire

/* src/ppm_pkg.sv */
package ppm_pkg;

  // ---------------------------------------------------------------
  // Register placement in configuration space
  // ---------------------------------------------------------------
  localparam logic [7:0] PM_CAP_BASE = 8'h34;
  localparam logic [7:0] PMCS_OFFSET = 8'h04;
  localparam logic [7:0] PMCS_ADDR = 8'h38;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int WAKE_FLAG_BIT = 15;
  localparam int SCALE_LSB = 13;
  localparam int SCALE_MSB = 14;
  localparam int SELECT_LSB = 9;
  localparam int SELECT_MSB = 12;
  localparam int WAKE_EN_BIT = 8;
  localparam int STATE_LSB = 0;
  localparam int STATE_MSB = 1;

  // ---------------------------------------------------------------
  // Reset values and options
  // ---------------------------------------------------------------
  localparam logic [15:0] PMCS_RESET = 16'h0000;
  localparam logic [1:0] SCALE_RESET = 2'h0;
  localparam logic [3:0] SELECT_RESET = 4'h0;
  localparam logic HAS_DATA_REG = 1'b0;
  localparam logic D1_SUPPORTED = 1'b1;
  localparam logic D2_SUPPORTED = 1'b1;

  // ---------------------------------------------------------------
  // Power state encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PPM_D0 = 2'h0,
    PPM_D1 = 2'h1,
    PPM_D2 = 2'h2,
    PPM_D3HOT = 2'h3
  } ppm_pstate_t;

  // Configuration access request from the PCI target logic
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] addr;
    logic [1:0] byteEn;
    logic [15:0] data;
  } ppm_cfg_req_t;

  // Read answer towards the PCI target logic
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ppm_cfg_rsp_t;

endpackage

/* src/ppm_wake_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module ppm_wake_unit
  import ppm_pkg::*;
(
  input wire logic sysClk,
  input wire logic rst,
  input wire logic auxRst,
  input wire logic coldWakeStrap,
  input wire logic wakeRequest,
  input wire logic enableWrite,
  input wire logic enableValue,
  input wire logic flagClear,
  output logic wakeEventFlag,
  output logic wakeAssertEnable,
  output logic coldWakeSupported,
  output logic wakePinOut,
  output logic wakePinOe
);

  typedef struct packed {
    logic strapDone;
    logic coldWake;
    logic flag;
    logic enable;
    logic pinOe;
  } ppm_wake_state_t;

  ppm_wake_state_t st;
  ppm_wake_state_t next_st;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Strap caught once after the aux reset is released
    if (!st.strapDone) begin
      next_st.strapDone = 1'b1;
      next_st.coldWake = coldWakeStrap; // see RULE14
    end
    if (flagClear) begin
      next_st.flag = 1'b0; // see RULE3
    end
    if (wakeRequest) begin
      next_st.flag = 1'b1; // see RULE2
    end
    if (enableWrite) begin
      next_st.enable = enableValue;
    end
    // Bus reset clears these only without cold wake support
    if (rst && !st.coldWake) begin
      next_st.flag = 1'b0; // see RULE5
      next_st.enable = 1'b0; // see RULE6
    end
    next_st.pinOe = next_st.flag && next_st.enable; // see RULE6
  end

  // Sticky bits live on the aux domain; defined zero at power-on
  always_ff @(posedge sysClk) begin
    if (auxRst) begin
      st <= '0; // see RULE15
    end else begin
      st <= next_st; // see RULE7
    end
  end

  assign wakeEventFlag = st.flag;
  assign wakeAssertEnable = st.enable;
  assign coldWakeSupported = st.coldWake;
  assign wakePinOe = st.pinOe;
  // Open drain: only ever pulls low
  assign wakePinOut = 1'b0;

endmodule
`default_nettype wire

/* dv/ppm_control_status_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ppm_control_status_checker
  import ppm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic auxRst,
  input wire logic wakeRequest,
  input wire ppm_cfg_req_t cfgReq,
  input wire ppm_cfg_rsp_t cfgRsp,
  input wire ppm_pstate_t powerStateField,
  input wire logic wakeEventFlag,
  input wire logic wakeAssertEnable,
  input wire logic coldWakeSupported,
  input wire logic wakePinOe
);
  logic hit;
  assign hit = cfgReq.addr == PMCS_ADDR;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || auxRst);
  a_read_answer: assert property (cfgReq.read |=> cfgRsp.valid)
    else $error("read not answered");
  a_bad_addr: assert property (cfgReq.read && !hit |=> !cfgRsp.data)
    else $error("unmapped read not zero");
  a_wake_sets: assert property (wakeRequest |=> wakeEventFlag)
    else $error("wake flag not set");
  a_flag_clear: assert property (cfgReq.write && hit && cfgReq.byteEn[1]
    && cfgReq.data[15] && !wakeRequest |=> !wakeEventFlag && !wakePinOe)
    else $error("wake flag not cleared");
  a_zero_keeps: assert property (cfgReq.write && !cfgReq.data[15]
    && wakeEventFlag |=> wakeEventFlag)
    else $error("wake flag lost");
  a_pin_gate: assert property (wakePinOe == (wakeEventFlag && wakeAssertEnable))
    else $error("wake pin not gated");
  a_bus_reset_clears: assert property (disable iff (auxRst)
    rst && !coldWakeSupported |=> !wakeEventFlag && !wakeAssertEnable)
    else $error("bus reset kept wake bits");
  a_fields_zero: assert property (cfgRsp.valid |->
    cfgRsp.data[14:9] == 6'h00 && cfgRsp.data[7:2] == 6'h00)
    else $error("scale or select not zero");
  a_state_read: assert property (cfgReq.read && hit |=>
    cfgRsp.data[1:0] == $past(powerStateField))
    else $error("state read wrong");
  a_state_write: assert property (cfgReq.write && hit && cfgReq.byteEn[0]
    |=> powerStateField == $past(cfgReq.data[1:0]))
    else $error("state write wrong");
endmodule
bind ppm_control_status ppm_control_status_checker u_chk (
  .sys_clk(sys_clk), .rst(rst), .auxRst(auxRst), .wakeRequest(wakeRequest),
  .cfgReq(cfgReq), .cfgRsp(cfgRsp), .powerStateField(powerStateField),
  .wakeEventFlag(wakeEventFlag), .wakeAssertEnable(wakeAssertEnable),
  .coldWakeSupported(coldWakeSupported), .wakePinOe(wakePinOe));
`default_nettype wire

/* dv/ppm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ppm_host_model
  import ppm_pkg::*;
(
  input wire logic sysClk,
  input wire ppm_cfg_rsp_t cfgRsp,
  output var ppm_cfg_req_t cfgReq
);
  initial cfgReq = '0;
  task automatic cfgWrite(input logic [7:0] a, input logic [1:0] be,
                          input logic [15:0] d);
    @(negedge sysClk);
    // Reserved bits always go out as zero
    cfgReq = '{1'b0, 1'b1, a, be, d & 16'hFF03};
    @(negedge sysClk);
    cfgReq = '0;
  endtask
  task automatic cfgRead(input logic [7:0] a, output ppm_cfg_rsp_t r);
    @(negedge sysClk);
    cfgReq = '{1'b1, 1'b0, a, 2'h3, 16'h0000};
    @(negedge sysClk);
    cfgReq = '0;
    r = cfgRsp;
  endtask
endmodule
`default_nettype wire

/* dv/pci_pm_control_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pci_pm_control_status_bench
  import ppm_pkg::*;
;
  logic sys_clk = 0, rst = 1, auxRst = 1, coldWakeStrap = 0, wakeRequest = 0;
  logic [1:0] dataScaleIn = 2'h3;
  ppm_cfg_req_t cfgReq;
  ppm_cfg_rsp_t cfgRsp, rd;
  ppm_pstate_t powerStateField;
  logic [3:0] dataSelect;
  logic powerStateChanged, wakeEventFlag, wakeAssertEnable;
  logic coldWakeSupported, wakePinOut, wakePinOe;
  int fails = 0, compares = 0, cycles = 0;
  wire logic [3:0] wake = {wakeEventFlag, wakeAssertEnable, wakePinOe, wakePinOut};
  always #10 sys_clk = ~sys_clk;
  ppm_control_status u_dut (.sys_clk(sys_clk), .rst(rst), .auxRst(auxRst),
    .coldWakeStrap(coldWakeStrap), .wakeRequest(wakeRequest),
    .dataScaleIn(dataScaleIn), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
    .powerStateField(powerStateField), .powerStateChanged(powerStateChanged),
    .dataSelect(dataSelect), .wakeEventFlag(wakeEventFlag),
    .wakeAssertEnable(wakeAssertEnable), .coldWakeSupported(coldWakeSupported),
    .wakePinOut(wakePinOut), .wakePinOe(wakePinOe));
  ppm_host_model u_host (.sysClk(sys_clk), .cfgRsp(cfgRsp), .cfgReq(cfgReq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic pulse_wake();
    @(negedge sys_clk) wakeRequest = 1;
    @(negedge sys_clk) wakeRequest = 0;
  endtask
  task automatic t_reset();
    u_host.cfgRead(PMCS_ADDR, rd);
    check({15'h0, rd.valid}, 16'h0001);
    check(rd.data, PMCS_RESET);
    check({8'h0, dataSelect, wake}, 16'h0000);
  endtask
  task automatic t_states();
    for (int s = 3; s >= 0; s--) begin
      u_host.cfgWrite(PMCS_ADDR, 2'h1, 16'(s));
      check({13'h0, powerStateField, powerStateChanged}, 16'(2 * s + 1));
      u_host.cfgRead(PMCS_ADDR, rd);
      check(rd.data, 16'(s));
    end
    u_host.cfgWrite(PMCS_ADDR, 2'h1, 16'h0000);
    check({15'h0, powerStateChanged}, 16'h0000);
  endtask
  task automatic t_wake();
    u_host.cfgWrite(PMCS_ADDR, 2'h2, 16'h0000);
    pulse_wake();
    check({12'h0, wake}, 16'h0008);
    u_host.cfgWrite(PMCS_ADDR, 2'h2, 16'h0000);
    check({12'h0, wake}, 16'h0008);
    u_host.cfgWrite(PMCS_ADDR, 2'h2, 16'h1F00);
    check({12'h0, wake}, 16'h000E);
    u_host.cfgRead(PMCS_ADDR, rd);
    check(rd.data, 16'h8100);
    u_host.cfgWrite(PMCS_ADDR, 2'h2, 16'h8100);
    check({12'h0, wake}, 16'h0004);
    pulse_wake();
    check({12'h0, wake}, 16'h000E);
    @(negedge sys_clk) rst = 1;
    @(negedge sys_clk) rst = 0;
    check({12'h0, wake}, 16'h0000);
  endtask
  task automatic t_bad_addr();
    u_host.cfgWrite(8'h3C, 2'h3, 16'h0003);
    check({14'h0, powerStateField}, 16'h0000);
    u_host.cfgRead(8'h3C, rd);
    check(rd.data, 16'h0000);
  endtask
  task automatic t_sticky();
    @(negedge sys_clk) coldWakeStrap = 1;
    auxRst = 1;
    @(negedge sys_clk) auxRst = 0;
    repeat (2) @(negedge sys_clk);
    check({15'h0, coldWakeSupported}, 16'h0001);
    pulse_wake();
    u_host.cfgWrite(PMCS_ADDR, 2'h2, 16'h0100);
    @(negedge sys_clk) rst = 1;
    @(negedge sys_clk) rst = 0;
    check({12'h0, wake}, 16'h000E);
  endtask
  // Far above the roughly 55 cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 0;
    auxRst = 0;
    repeat (2) @(negedge sys_clk);
    t_reset();
    t_states();
    t_wake();
    t_bad_addr();
    t_sticky();
    finish_test();
  end
endmodule
`default_nettype wire
